//--- pkg/rif_regs.svh
// frame constants for the route indicator framer
`ifndef RIF_REGS_SVH
`define RIF_REGS_SVH
`define RIF_START_DELIM 8'h7E
`define RIF_TYPE_ROUTE_REC 8'hA1
`define RIF_TYPE_MTO_REQ 8'hA3
`define RIF_OFS_TYPE 8'h03
`define RIF_OFS_ADDR64 8'h04
`define RIF_OFS_ADDR64_LAST 8'h0B
`define RIF_OFS_NET_MSB 8'h0C
`define RIF_OFS_NET_LSB 8'h0D
`define RIF_OFS_OPTS 8'h0E
`define RIF_OFS_COUNT 8'h0F
`define RIF_OFS_RELAY 8'h10
`define RIF_OPT_ACKED 8'h01
`define RIF_OPT_BCAST 8'h02
`define RIF_RESERVED_VAL 8'h00
`define RIF_CSUM_BASE 8'hFF
`define RIF_MTO_LEN 8'h0C
`define RIF_RR_BASE_LEN 8'h0D
`endif

//--- pkg/rif_pkg.sv
// types for the route indicator framer
package rif_pkg;
  typedef struct packed {
    logic [63:0] addr64;
    logic [15:0] addr16;
    logic [7:0] rx_opts;
  } rif_src_t;
  typedef enum logic [2:0] {
    RIF_IDLE = 3'b000,
    RIF_DELIM = 3'b001,
    RIF_LEN_MSB = 3'b011,
    RIF_LEN_LSB = 3'b010,
    RIF_BODY = 3'b110,
    RIF_CSUM = 3'b111
  } rif_state_t;
endpackage

//--- design/rif_framer.sv
// route record and many-to-one request frame generator
//
// Overview of operation
// - A received route record makes a frame whose type byte is 0xA1.
// - The route record frame carries the 64-bit source at 4-11 and 16-bit source at 12-13.
// - Offset 14 of the route record frame is the receive options byte.
// - Offset 15 of the route record frame is the count of relay hops only.
// - From offset 16 each relay address follows as two bytes, destination side first.
// - A received many-to-one route request makes a frame whose type byte is 0xA3.
// - The request frame has the 64-bit source at 4-11 and a zero byte at 14.
// - The request frame has the 16-bit source at 12-13, high byte first.
`timescale 1ns/100ps
`include "rif_regs.svh"
module rif_framer
  import rif_pkg::*;
#(
  parameter int MAX_HOPS = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // indication request, relay list index 0 neighbours the destination
  input wire logic rr_valid,
  input wire logic mto_valid,
  output logic req_ready,
  input wire rif_src_t src,
  input wire logic [7:0] hop_count,
  input wire logic [MAX_HOPS*16-1:0] hop_list,
  // serial byte stream to host
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic tx_last
);
  rif_state_t state_reg, state_next;
  logic [7:0] ofs_reg;
  logic [7:0] sum_reg;
  logic is_rr_reg;
  rif_src_t src_reg;
  logic [7:0] hops_reg;
  logic [MAX_HOPS*16-1:0] list_reg;
  logic [7:0] len_reg;
  logic [7:0] tx_data_reg;
  logic tx_valid_reg;
  logic tx_last_reg;

  function automatic logic [7:0] pick_byte(input logic [63:0] w, input logic [2:0] idx);
    pick_byte = w[8*(7-idx) +: 8];
  endfunction

  wire logic take = (state_reg == RIF_IDLE) && (rr_valid || mto_valid);
  wire logic adv = !tx_valid_reg || tx_ready;
  wire logic [7:0] clamp_hops = (hop_count > 8'(MAX_HOPS)) ? 8'(MAX_HOPS) : hop_count;
  wire logic [7:0] rel = ofs_reg - `RIF_OFS_RELAY;
  wire logic [7:0] hop_idx = {1'b0, rel[7:1]};
  wire logic [15:0] hop_word = list_reg[16*hop_idx +: 16];
  wire logic [7:0] last_ofs = `RIF_OFS_TYPE + len_reg - 8'h01;
  logic [7:0] body_byte;

  assign req_ready = (state_reg == RIF_IDLE);

  always_comb begin
    body_byte = 8'h00;
    if (ofs_reg == `RIF_OFS_TYPE) begin
      body_byte = is_rr_reg ? `RIF_TYPE_ROUTE_REC : `RIF_TYPE_MTO_REQ;
    end else if (ofs_reg <= `RIF_OFS_ADDR64_LAST) begin
      body_byte = pick_byte(src_reg.addr64, 3'(ofs_reg - `RIF_OFS_ADDR64));
    end else if (ofs_reg == `RIF_OFS_NET_MSB) begin
      body_byte = src_reg.addr16[15:8];
    end else if (ofs_reg == `RIF_OFS_NET_LSB) begin
      body_byte = src_reg.addr16[7:0];
    end else if (ofs_reg == `RIF_OFS_OPTS) begin
      body_byte = is_rr_reg ? src_reg.rx_opts : `RIF_RESERVED_VAL;
    end else if (ofs_reg == `RIF_OFS_COUNT) begin
      body_byte = hops_reg;
    end else begin
      body_byte = rel[0] ? hop_word[7:0] : hop_word[15:8];
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      RIF_IDLE: if (take) state_next = RIF_DELIM;
      RIF_DELIM: if (adv) state_next = RIF_LEN_MSB;
      RIF_LEN_MSB: if (adv) state_next = RIF_LEN_LSB;
      RIF_LEN_LSB: if (adv) state_next = RIF_BODY;
      RIF_BODY: if (adv && ofs_reg == last_ofs) state_next = RIF_CSUM;
      RIF_CSUM: if (adv) state_next = RIF_IDLE;
      default: state_next = RIF_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg <= RIF_IDLE;
      ofs_reg <= 8'h00;
      sum_reg <= 8'h00;
      is_rr_reg <= 1'b0;
      src_reg <= '0;
      hops_reg <= 8'h00;
      list_reg <= '0;
      len_reg <= 8'h00;
      tx_data_reg <= 8'h00;
      tx_valid_reg <= 1'b0;
      tx_last_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (take) begin
        // route record wins when both arrive together
        is_rr_reg <= rr_valid;
        src_reg <= src;
        hops_reg <= rr_valid ? clamp_hops : 8'h00;
        list_reg <= hop_list;
        len_reg <= rr_valid ? 8'(`RIF_RR_BASE_LEN + 2 * clamp_hops) : `RIF_MTO_LEN;
        ofs_reg <= `RIF_OFS_TYPE;
        sum_reg <= 8'h00;
      end
      if (adv) begin
        tx_valid_reg <= (state_reg != RIF_IDLE);
        tx_last_reg <= (state_reg == RIF_CSUM);
        case (state_reg)
          RIF_DELIM: tx_data_reg <= `RIF_START_DELIM;
          RIF_LEN_MSB: tx_data_reg <= 8'h00;
          RIF_LEN_LSB: tx_data_reg <= len_reg;
          RIF_BODY: begin
            tx_data_reg <= body_byte;
            sum_reg <= sum_reg + body_byte;
            ofs_reg <= ofs_reg + 8'h01;
          end
          RIF_CSUM: tx_data_reg <= `RIF_CSUM_BASE - sum_reg;
          default: tx_data_reg <= tx_data_reg;
        endcase
      end
    end
  end

  assign tx_data = tx_data_reg;
  assign tx_valid = tx_valid_reg;
  assign tx_last = tx_last_reg;

  property p_delim_after_take;
    @(posedge ref_clk) disable iff (srst)
    take |=> (state_reg == RIF_DELIM);
  endproperty
  a_delim_after_take: assert property (p_delim_after_take) else $error("no delimiter state");

  property p_delim_byte;
    @(posedge ref_clk) disable iff (srst)
    (state_reg == RIF_DELIM && adv) |=> (tx_valid && tx_data == 8'h7E);
  endproperty
  a_delim_byte: assert property (p_delim_byte) else $error("bad delimiter");

  property p_type_rr;
    @(posedge ref_clk) disable iff (srst)
    (state_reg == RIF_BODY && adv && ofs_reg == 8'h03 && is_rr_reg) |=> tx_data == 8'hA1;
  endproperty
  a_type_rr: assert property (p_type_rr) else $error("bad route record type");

  property p_type_mto;
    @(posedge ref_clk) disable iff (srst)
    (state_reg == RIF_BODY && adv && ofs_reg == 8'h03 && !is_rr_reg) |=> tx_data == 8'hA3;
  endproperty
  a_type_mto: assert property (p_type_mto) else $error("bad request type");

  property p_addr_msb;
    @(posedge ref_clk) disable iff (srst)
    (state_reg == RIF_BODY && adv && ofs_reg == 8'h04) |=> tx_data == src_reg.addr64[63:56];
  endproperty
  a_addr_msb: assert property (p_addr_msb) else $error("bad 64-bit msb");

  property p_net_msb;
    @(posedge ref_clk) disable iff (srst)
    (state_reg == RIF_BODY && adv && ofs_reg == 8'h0C) |=> tx_data == src_reg.addr16[15:8];
  endproperty
  a_net_msb: assert property (p_net_msb) else $error("bad 16-bit msb");

  property p_opts;
    @(posedge ref_clk) disable iff (srst)
    (state_reg == RIF_BODY && adv && ofs_reg == 8'h0E)
      |=> tx_data == (is_rr_reg ? src_reg.rx_opts : 8'h00);
  endproperty
  a_opts: assert property (p_opts) else $error("bad options byte");

  property p_reserved;
    @(posedge ref_clk) disable iff (srst)
    (state_reg == RIF_BODY && adv && ofs_reg == 8'h0E && !is_rr_reg) |=> tx_data == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved not zero");

  property p_count;
    @(posedge ref_clk) disable iff (srst)
    (state_reg == RIF_BODY && adv && ofs_reg == 8'h0F) |=> tx_data == hops_reg;
  endproperty
  a_count: assert property (p_count) else $error("bad relay count");

  property p_first_hop;
    @(posedge ref_clk) disable iff (srst)
    (state_reg == RIF_BODY && adv && ofs_reg == 8'h10) |=> tx_data == list_reg[15:8];
  endproperty
  a_first_hop: assert property (p_first_hop) else $error("bad first relay");

  c_rr: cover property (@(posedge ref_clk) take && rr_valid);
  c_mto: cover property (@(posedge ref_clk) take && !rr_valid);
  c_stall: cover property (@(posedge ref_clk) tx_valid && !tx_ready);
  c_end: cover property (@(posedge ref_clk) tx_valid && tx_ready && tx_last);
endmodule

//--- verif/rif_host_model.sv
// host controller model that takes frame bytes, stalling at random when asked
`timescale 1ns/100ps
module rif_host_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // byte stream from the framer
  input wire logic tx_valid,
  input wire logic slow,
  output logic tx_ready
);
  initial tx_ready = 1'b0;
  // ready changes only off the sampling edge; slow mode drops it one time in four
  always @(negedge ref_clk) begin
    tx_ready <= !srst && (!slow || ($urandom_range(3) != 0));
  end
endmodule

//--- verif/route_indicator_framer_tb_top.sv
// self-checking bench for the route indicator framer
`timescale 1ns/100ps
module route_indicator_framer_tb_top;
  import rif_pkg::*;
  localparam int MH = 4;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic rr_valid = 1'b0;
  logic mto_valid = 1'b0;
  logic slow = 1'b0;
  logic req_ready, tx_valid, tx_ready, tx_last;
  logic [7:0] tx_data;
  logic [7:0] hop_count = 8'h00;
  logic [MH*16-1:0] hop_list = '0;
  rif_src_t src = '0;
  logic [8:0] q[$];
  int fail_count = 0;
  int checks = 0;
  always #12.5 ref_clk = ~ref_clk;
  rif_framer #(.MAX_HOPS(MH)) i_rif_framer (.ref_clk(ref_clk), .srst(srst),
    .rr_valid(rr_valid), .mto_valid(mto_valid), .req_ready(req_ready), .src(src),
    .hop_count(hop_count), .hop_list(hop_list), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_last(tx_last));
  rif_host_model i_rif_host_model (.ref_clk(ref_clk), .srst(srst), .tx_valid(tx_valid),
    .slow(slow), .tx_ready(tx_ready));
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one request, its frame noted byte by byte
  task automatic send(input logic rr, input logic mto, input int n);
    logic [7:0] b[$];
    logic [7:0] sum;
    int k;
    k = (n > MH) ? MH : n;
    do @(negedge ref_clk); while (!req_ready);
    rr_valid = rr;
    mto_valid = mto;
    hop_count = 8'(n);
    b.push_back(rr ? 8'hA1 : 8'hA3);
    for (int i = 7; i >= 0; i--) b.push_back(src.addr64[8*i+:8]);
    b.push_back(src.addr16[15:8]);
    b.push_back(src.addr16[7:0]);
    b.push_back(rr ? src.rx_opts : 8'h00);
    if (rr) begin
      b.push_back(8'(k));
      for (int i = 0; i < k; i++) begin
        b.push_back(hop_list[16*i+8+:8]);
        b.push_back(hop_list[16*i+:8]);
      end
    end
    q.push_back(9'h07E);
    q.push_back(9'h000);
    q.push_back({1'b0, 8'(b.size())});
    sum = 8'h00;
    foreach (b[i]) begin
      sum += b[i];
      q.push_back({1'b0, b[i]});
    end
    q.push_back({1'b1, 8'hFF - sum});
    @(negedge ref_clk);
    rr_valid = 1'b0;
    mto_valid = 1'b0;
  endtask
  // each accepted byte is matched against the oldest note
  always @(posedge ref_clk) begin
    if (!srst && tx_valid && tx_ready) begin
      check({tx_last, tx_data}, (q.size() != 0) ? q.pop_front() : 9'bx);
    end
  end
  initial begin
    #(25 * 20000);
    fail_count++;
    stop_test();
  end
  initial begin
    void'($urandom(32'h0260cef9));
    repeat (8) @(negedge ref_clk);
    srst = 1'b0;
    src = '{64'h0013_A200_4040_1122, 16'h3344, 8'h01};
    hop_list = 64'h0000_AABB_CCDD_EEFF;
    send(1'b1, 1'b0, 3);
    src.addr16 = 16'h0000;
    send(1'b0, 1'b1, 0);
    src.rx_opts = 8'h02;
    send(1'b1, 1'b0, 0);
    // request while a frame is in flight is dropped
    mto_valid = 1'b1;
    @(negedge ref_clk);
    mto_valid = 1'b0;
    send(1'b1, 1'b1, 2);
    send(1'b1, 1'b0, 6);
    // reset in mid-frame abandons it
    repeat (5) @(negedge ref_clk);
    srst = 1'b1;
    q.delete();
    @(negedge ref_clk);
    srst = 1'b0;
    slow = 1'b1;
    for (int i = 0; i < 14; i++) begin
      src.addr64 = {$urandom, $urandom};
      src.addr16 = 16'($urandom);
      src.rx_opts = i[0] ? 8'h01 : 8'h02;
      hop_list = {$urandom, $urandom};
      send(1'($urandom_range(1)), 1'b1, $urandom_range(6));
    end
    for (int i = 0; i < 200 && q.size() != 0; i++) @(negedge ref_clk);
    @(negedge ref_clk);
    check({7'h00, req_ready, tx_valid}, {7'h00, 2'b10});
    check(9'(q.size()), 9'h000);
    stop_test();
  end
endmodule
